// File: input_conditioner_pkg.sv
// shared constants for the digital input conditioner
package input_conditioner_pkg;
  // clock and scan timing
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned SCAN_PERIOD_US   = 5000;
  localparam int unsigned SCAN_CYCLES      = CLK_HZ / 1_000_000 * SCAN_PERIOD_US;
  // delay settings count milliseconds; a millisecond tick drives the timers
  localparam int unsigned MS_PERIOD_US     = 1000;
  localparam int unsigned MS_CYCLES        = CLK_HZ / 1_000_000 * MS_PERIOD_US;
  localparam int unsigned AC_EXTRA_MS      = 30;
  localparam int unsigned DELAY_MAX_MS     = 1_800_000;
  localparam int unsigned DELAY_W          = 21;
  // thresholds in 0.1 V steps, measured voltage in 0.001 V steps
  localparam int unsigned LEVEL_W          = 12;
  localparam int unsigned VOLT_W           = 19;
  localparam logic [11:0] PICKUP_RESET     = 12'h370;  // 88.0 V
  localparam logic [11:0] DROPOUT_RESET    = 12'h258;  // 60.0 V
  localparam int unsigned MV_PER_STEP      = 100;
  localparam int unsigned AC_DROP_PERCENT  = 10;
  localparam int unsigned COUNT_W          = 32;
  // sense select encoding
  localparam logic        SENSE_NO         = 1'b0;
  localparam logic        SENSE_NC         = 1'b1;
endpackage

// File: qualify_timer.sv
// qualification timer: holds a raw level until it stays stable long enough
module qualify_timer
  import input_conditioner_pkg::*;
#(
  parameter int unsigned W = DELAY_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         scan_tick_in,
  input  wire logic         ms_tick_in,
  input  wire logic         raw_in,
  input  wire logic [W-1:0] rise_ms_in,
  input  wire logic [W-1:0] fall_ms_in,
  output logic              state_out
);
  logic [W:0] elapsed;

  // a zero-width delay field cannot be served
  if (W < 1) begin : g_bad_width
    $error("delay width must be at least one bit");
  end

  // count ms while raw differs from output; a return to agreement restarts it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      elapsed   <= '0;
      state_out <= 1'b0;
    end else if (raw_in == state_out) begin
      elapsed <= '0;
    end else if (scan_tick_in &&
                 elapsed >= {1'b0, (raw_in ? rise_ms_in : fall_ms_in)}) begin
      state_out <= raw_in;
      elapsed   <= '0;
    end else if (ms_tick_in && elapsed != '1) begin
      elapsed <= elapsed + 1'b1;
    end
  end
endmodule

// File: digital_input_conditioner.sv
// one conditioned input channel: hysteresis, sense, qualify, transition count
module digital_input_conditioner
  import input_conditioner_pkg::*;
#(
  parameter int unsigned SCAN_DIV = SCAN_CYCLES,
  parameter int unsigned MS_DIV   = MS_CYCLES
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic [VOLT_W-1:0]  channel_mv_in,
  input  wire logic               cfg_load_in,
  input  wire logic               input_sense_select_in,
  input  wire logic [LEVEL_W-1:0] pickup_level_in,
  input  wire logic [LEVEL_W-1:0] dropout_level_in,
  input  wire logic [DELAY_W-1:0] rise_qualify_delay_in,
  input  wire logic [DELAY_W-1:0] fall_qualify_delay_in,
  input  wire logic               alternating_supply_option_in,
  input  wire logic               clear_count_in,
  output logic                    input_channel_out,
  output logic                    raw_state_out,
  output logic                    scan_tick_out,
  output logic [VOLT_W-1:0]       voltage_now_out,
  output logic [COUNT_W-1:0]      transition_count_out
);
  //////////////////////////////////////////////////////////////////////////////
  // parameter checks, refused at elaboration

  // the scan counter is 24 bits and the millisecond counter 16 bits wide
  if (SCAN_DIV < 2 || SCAN_DIV > 32'h00FF_FFFF) begin : g_bad_scan_div
    $error("scan divider out of range");
  end
  if (MS_DIV < 2 || MS_DIV > 32'h0001_0000) begin : g_bad_ms_div
    $error("millisecond divider out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings, latched on a load strobe so software writes one whole set
  // a change takes effect at the next scan tick, never in between

  logic                    sense;
  logic [LEVEL_W-1:0]      pickup;
  logic [LEVEL_W-1:0]      dropout;
  logic [DELAY_W-1:0]      rise_ms;
  logic [DELAY_W-1:0]      fall_ms;
  logic                    ac_mode;

  // delays above the documented ceiling are clipped rather than wrapped
  function automatic logic [DELAY_W-1:0] clip_ms(input logic [DELAY_W-1:0] v);
    clip_ms = (v > DELAY_W'(DELAY_MAX_MS)) ? DELAY_W'(DELAY_MAX_MS) : v;
  endfunction

  // sense select, normally open after reset
  always_ff @(posedge clk_in) begin
    if (rst_in)
      sense <= SENSE_NO;
    else if (cfg_load_in)
      sense <= input_sense_select_in;
  end

  // both levels in 0.1 V steps; dropout is kept while alternating mode
  // hides it, so turning the option off restores the user's value
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pickup  <= PICKUP_RESET;
      dropout <= DROPOUT_RESET;
    end else if (cfg_load_in) begin
      pickup  <= pickup_level_in;
      dropout <= dropout_level_in;
    end
  end

  // qualify delays in milliseconds, zero after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rise_ms <= '0;
      fall_ms <= '0;
    end else if (cfg_load_in) begin
      rise_ms <= clip_ms(rise_qualify_delay_in);
      fall_ms <= clip_ms(fall_qualify_delay_in);
    end
  end

  // alternating supply option, off after reset
  always_ff @(posedge clk_in) begin
    if (rst_in)
      ac_mode <= 1'b0;
    else if (cfg_load_in)
      ac_mode <= alternating_supply_option_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // dividers: scan tick and millisecond tick
  // both restart on reset, so their relative phase is fixed

  logic [23:0] scan_cnt;
  logic [15:0] ms_cnt;
  logic        scan_tick;
  logic        ms_tick;

  // scan divider: one tick every SCAN_DIV clocks, the first SCAN_DIV
  // clocks after reset, so an update is at most one scan late
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scan_cnt  <= '0;
      scan_tick <= 1'b0;
    end else if (scan_cnt == 24'(SCAN_DIV - 1)) begin
      scan_cnt  <= '0;
      scan_tick <= 1'b1;
    end else begin
      scan_cnt  <= scan_cnt + 24'h000001;
      scan_tick <= 1'b0;
    end
  end

  // millisecond divider; delays are only acted on at a scan tick, so a
  // delay may qualify up to one scan later than its setting
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 16'(MS_DIV - 1)) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // thresholds in millivolts and hysteresis comparator
  // all three values are widened to millivolts before comparing

  logic [VOLT_W+4:0] pickup_mv;
  logic [VOLT_W+4:0] dropout_mv;
  logic [VOLT_W+4:0] volt_ext;

  // alternating mode: dropout is a tenth of pickup, i.e. pickup steps * 10 mV
  always_comb begin
    pickup_mv = (VOLT_W+5)'(pickup) * (VOLT_W+5)'(MV_PER_STEP);
    volt_ext  = (VOLT_W+5)'(channel_mv_in);
    if (ac_mode)
      dropout_mv = (VOLT_W+5)'(pickup) *
                   (VOLT_W+5)'(MV_PER_STEP * AC_DROP_PERCENT / 100);
    else
      dropout_mv = (VOLT_W+5)'(dropout) * (VOLT_W+5)'(MV_PER_STEP);
  end

  logic energised;
  logic next_energised;
  logic raw_level;

  // sense select decides what an energised input reads as
  function automatic logic apply_sense(input logic sel, input logic level);
    apply_sense = (sel == SENSE_NC) ? ~level : level;
  endfunction

  // above pickup energises, below dropout releases, equality holds
  always_comb begin
    if (volt_ext > pickup_mv)
      next_energised = 1'b1;
    else if (volt_ext < dropout_mv)
      next_energised = 1'b0;
    else
      next_energised = energised;
  end

  // comparator state moves only on the scan tick
  always_ff @(posedge clk_in) begin
    if (rst_in)
      energised <= 1'b0;
    else if (scan_tick)
      energised <= next_energised;
  end

  // sense is applied at the tick as well: a load between scans must not
  // move the raw state before the next scan has looked at the input
  always_ff @(posedge clk_in) begin
    if (rst_in)
      raw_level <= 1'b0;
    else if (scan_tick)
      raw_level <= apply_sense(sense, next_energised);
  end

  //////////////////////////////////////////////////////////////////////////////
  // qualification: alternating mode stretches only the falling delay

  logic [DELAY_W-1:0] fall_total;
  logic [DELAY_W:0]   fall_sum;
  logic               qualified;

  // alternating mode adds 30 ms to the fall delay; a sum beyond the
  // timer range saturates instead of wrapping to a short delay
  always_comb begin
    fall_sum   = {1'b0, fall_ms} + (DELAY_W+1)'(ac_mode ? AC_EXTRA_MS : 0);
    fall_total = fall_sum[DELAY_W] ? '1 : fall_sum[DELAY_W-1:0];
  end

  // one timer serves both directions; the pending direction picks the delay
  qualify_timer #(
    .W(DELAY_W)
  ) u_qualify (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .scan_tick_in (scan_tick),
    .ms_tick_in   (ms_tick),
    .raw_in       (raw_level),
    .rise_ms_in   (rise_ms),
    .fall_ms_in   (fall_total),
    .state_out    (qualified)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs and transition counter
  // every port below comes straight from a flip-flop

  logic prev_state;

  // last qualified state, for the rising-edge detect of the counter
  always_ff @(posedge clk_in) begin
    if (rst_in)
      prev_state <= 1'b0;
    else
      prev_state <= qualified;
  end

  // conditioned state, one clock behind the qualify timer
  always_ff @(posedge clk_in) begin
    if (rst_in)
      input_channel_out <= 1'b0;
    else
      input_channel_out <= qualified;
  end

  // raw state before the qualify delays, for observation
  always_ff @(posedge clk_in) begin
    if (rst_in)
      raw_state_out <= 1'b0;
    else
      raw_state_out <= raw_level;
  end

  // scan pulse, one cycle behind the internal tick
  always_ff @(posedge clk_in) begin
    if (rst_in)
      scan_tick_out <= 1'b0;
    else
      scan_tick_out <= scan_tick;
  end

  // present voltage in millivolts, refreshed every clock rather than per
  // scan so software always sees the newest converter value
  always_ff @(posedge clk_in) begin
    if (rst_in)
      voltage_now_out <= '0;
    else
      voltage_now_out <= channel_mv_in;
  end

  logic               count_rise;
  logic [COUNT_W-1:0] next_count;

  // one-cycle rise of the qualified state; the counter wraps after 2^32-1
  assign count_rise = qualified && !prev_state;

  // a rising edge in the clear cycle still counts: set beats clear
  always_comb begin
    if (count_rise && clear_count_in)
      next_count = COUNT_W'(1);
    else if (count_rise)
      next_count = transition_count_out + 1'b1;
    else if (clear_count_in)
      next_count = '0;
    else
      next_count = transition_count_out;
  end

  // counter register, lands on the same edge as the state output
  always_ff @(posedge clk_in) begin
    if (rst_in)
      transition_count_out <= '0;
    else
      transition_count_out <= next_count;
  end
endmodule

// File: volt_source.sv
// far side model: measured channel voltage from the front end
module volt_source
  import input_conditioner_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [VOLT_W-1:0] level_in,
  output logic      [VOLT_W-1:0] mv_out
);
  // converter settles one clock after a new level is asked for
  always_ff @(posedge clk_in) begin
    mv_out <= level_in;
  end
endmodule

// File: input_cond_monitor.sv
// assertion checker for the conditioned input channel ports
module input_cond_monitor
  import input_conditioner_pkg::*;
#(
  parameter int unsigned SCAN_DIV = SCAN_CYCLES
) (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic [VOLT_W-1:0]  channel_mv_in,
  input wire logic               cfg_load_in,
  input wire logic               input_sense_select_in,
  input wire logic [LEVEL_W-1:0] pickup_level_in,
  input wire logic [LEVEL_W-1:0] dropout_level_in,
  input wire logic               alternating_supply_option_in,
  input wire logic               clear_count_in,
  input wire logic               input_channel_out,
  input wire logic               raw_state_out,
  input wire logic               scan_tick_out,
  input wire logic [VOLT_W-1:0]  voltage_now_out,
  input wire logic [COUNT_W-1:0] transition_count_out
);
  logic               sense, ac, seen, hi, lo;
  logic [LEVEL_W-1:0] pick, drop;
  logic [31:0]        gap;
  ////////////////////////////////////////
  // settings shadow, loaded on the same strobe as the design
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {sense, ac, pick, drop} <= {SENSE_NO, 1'b0, PICKUP_RESET, DROPOUT_RESET};
    end else if (cfg_load_in) begin
      {sense, ac, pick, drop} <= {input_sense_select_in,
        alternating_supply_option_in, pickup_level_in, dropout_level_in};
    end
  end
  // cycles between pulses; seen skips the partial first period
  always_ff @(posedge clk_in) begin
    gap <= (rst_in || scan_tick_out) ? 32'h0 : gap + 32'h1;
    seen <= !rst_in && (seen || scan_tick_out);
  end
  // voltage_now_out holds the tick-edge sample while the pulse is up
  assign hi = 32'(voltage_now_out) > 32'(pick) * 32'h64;
  assign lo = 32'(voltage_now_out) <
              (ac ? 32'(pick) * 32'hA : 32'(drop) * 32'h64);
  ////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_volt_track: assert property (!$past(rst_in) |->
    voltage_now_out == $past(channel_mv_in)) else $error("voltage lag");
  a_tick_period: assert property (scan_tick_out && seen |->
    gap == SCAN_DIV - 1) else $error("scan period");
  a_raw_at_tick: assert property ($changed(raw_state_out) |->
    scan_tick_out || $past(scan_tick_out)) else $error("raw off tick");
  a_raw_high: assert property (scan_tick_out && hi |=>
    raw_state_out == !sense) else $error("above pickup");
  a_raw_low: assert property (scan_tick_out && lo |=>
    raw_state_out == sense) else $error("below dropout");
  a_raw_hold: assert property (scan_tick_out && !hi && !lo |=>
    raw_state_out == $past(raw_state_out, 2)) else $error("hysteresis");
  a_count_step: assert property ($rose(input_channel_out) |->
    transition_count_out == ($past(clear_count_in) ? 32'h1 :
    $past(transition_count_out) + 32'h1)) else $error("count step");
  a_count_clear: assert property (clear_count_in |=>
    transition_count_out == ($rose(input_channel_out) ? 32'h1 : 32'h0))
    else $error("count clear");
  c_rise: cover property ($rose(input_channel_out));
  c_clear: cover property (clear_count_in);
  c_ac_low: cover property (scan_tick_out && ac && lo);
endmodule
bind digital_input_conditioner input_cond_monitor #(.SCAN_DIV(SCAN_DIV)) mon_u (
  .clk_in, .rst_in, .channel_mv_in, .cfg_load_in, .input_sense_select_in,
  .pickup_level_in, .dropout_level_in, .alternating_supply_option_in,
  .clear_count_in, .input_channel_out, .raw_state_out, .scan_tick_out,
  .voltage_now_out, .transition_count_out);

// File: digital_input_conditioner_tb_top.sv
// self-checking bench for one conditioned input channel
module digital_input_conditioner_tb_top
  import input_conditioner_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic [VOLT_W-1:0]  level = '0;
  logic [VOLT_W-1:0]  channel_mv_in;
  logic               cfg_load_in = 1'b0;
  logic               input_sense_select_in = SENSE_NO;
  logic [LEVEL_W-1:0] pickup_level_in = PICKUP_RESET;
  logic [LEVEL_W-1:0] dropout_level_in = DROPOUT_RESET;
  logic [DELAY_W-1:0] rise_qualify_delay_in = '0;
  logic [DELAY_W-1:0] fall_qualify_delay_in = '0;
  logic               alternating_supply_option_in = 1'b0;
  logic               clear_count_in = 1'b0;
  logic               input_channel_out, raw_state_out, scan_tick_out, last;
  logic [VOLT_W-1:0]  voltage_now_out;
  logic [COUNT_W-1:0] transition_count_out;
  logic               exp_val[$];
  int                 exp_tick[$];
  int                 bad_count = 0, n_compared = 0, tick_no = 0, rises = 0;
  int                 p, d;
  volt_source src_u (.clk_in, .level_in(level), .mv_out(channel_mv_in));
  // short scan and millisecond divisors: 50 and 10 cycles
  digital_input_conditioner #(.SCAN_DIV(50), .MS_DIV(10)) dut_u (
    .clk_in, .rst_in, .channel_mv_in, .cfg_load_in, .input_sense_select_in,
    .pickup_level_in, .dropout_level_in, .rise_qualify_delay_in,
    .fall_qualify_delay_in, .alternating_supply_option_in, .clear_count_in,
    .input_channel_out, .raw_state_out, .scan_tick_out, .voltage_now_out,
    .transition_count_out);
  ////////////////////////////////////////
  initial forever #25 clk_in = ~clk_in;
  // scan counter; lags one edge, equally for raw and qualified changes
  always @(posedge clk_in) if (scan_tick_out === 1'b1) tick_no <= tick_no + 1;
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_ticks(input int n);
    int t0, k;
    t0 = tick_no;
    for (k = 0; k < 60 * n + 60 && tick_no < t0 + n; k++) @(negedge clk_in);
    if (tick_no < t0 + n) begin
      bad_count++;
      final_report();
    end
  endtask
  // move the level, expect a raw change, note when the output must follow;
  // n is the scan count the qualify delay needs, ms counted with +-1 slack
  task automatic step(input int mv, input logic val, input int n);
    int i;
    @(posedge clk_in) level <= VOLT_W'(mv);
    for (i = 0; i < 400 && raw_state_out !== val; i++) @(negedge clk_in);
    check("raw", raw_state_out, val);
    if (i == 400) final_report();
    exp_val.push_back(val);
    exp_tick.push_back(tick_no + n);
    if (val) rises++;
    wait_ticks(n + 1);
  endtask
  task automatic hold(input int mv);
    logic was;
    was = raw_state_out;
    @(posedge clk_in) level <= VOLT_W'(mv);
    wait_ticks(2);
    check("hold", raw_state_out, was);
  endtask
  // load right after a pulse so no tick edge sees half a load
  task automatic load(input logic s, input int pk, input int dr,
                      input int r, input int f, input logic a);
    wait_ticks(1);
    @(posedge clk_in);
    {input_sense_select_in, alternating_supply_option_in} <= {s, a};
    pickup_level_in <= LEVEL_W'(pk);
    dropout_level_in <= LEVEL_W'(dr);
    rise_qualify_delay_in <= DELAY_W'(r);
    fall_qualify_delay_in <= DELAY_W'(f);
    cfg_load_in <= 1'b1;
    @(posedge clk_in) cfg_load_in <= 1'b0;
  endtask
  // watcher: each qualified change is matched to the oldest note
  always @(negedge clk_in) begin
    if (rst_in === 1'b0 && input_channel_out !== last) begin
      if (exp_val.size() == 0) check("spare", 1, 0);
      else begin
        check("state", input_channel_out, exp_val.pop_front());
        check("scan", tick_no, exp_tick.pop_front());
      end
    end
    last = input_channel_out;
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h6C1F));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    check("reset count", transition_count_out, 0);
    hold(88000);
    step(88001, 1, 1);
    hold(60000);
    step(59999, 0, 1);
    $display("test defaults done");
    p = 160 + int'($urandom % 1841);
    d = 100 + int'($urandom % (p - 100));
    hold(0);
    load(SENSE_NC, p, d, 0, 0, 1'b0);
    step(0, 1, 1);
    step(p * 100 + 1, 0, 1);
    step(d * 100 - 1, 1, 1);
    $display("test closed sense done");
    hold(0);
    load(SENSE_NO, p, p - 1, 18, 3, 1'b1);
    step(0, 0, 7);
    step(p * 100 + 1, 1, 4);
    hold(p * 10);
    step(p * 10 - 1, 0, 7);
    $display("test alternating done");
    check("count", transition_count_out, rises);
    @(posedge clk_in) clear_count_in <= 1'b1;
    @(posedge clk_in) clear_count_in <= 1'b0;
    @(negedge clk_in);
    check("cleared", transition_count_out, 0);
    step(p * 100 + 1, 1, 4);
    check("recount", transition_count_out, 1);
    $display("test counter done");
    final_report();
  end
endmodule
